// ===== src/tscan_consts.vh
/*
 constants for the touch scan control block: field positions, reset values,
 trigger source codes and prescaler and scan-count limits.
 assumes inclusion by bare name from the design files.
*/
`ifndef TSCAN_CONSTS_VH
`define TSCAN_CONSTS_VH

`define TSCAN_NUM_ELECTRODES  16
`define TSCAN_DIV_FIELD_MAX   3'h7
`define TSCAN_NSCAN_FIELD_W   5
`define TSCAN_CNT_RESET       16'h0000
`define TSCAN_CUR_64UA        3'h7
`define TSCAN_CUR_8UA         3'h4
`define TSCAN_TRIG_RTC        2'h0
`define TSCAN_TRIG_MODULO_TIMER_0      2'h1
`define TSCAN_TRIG_TIMER2     2'h2
`define TSCAN_RAIL_MSB        4
`define TSCAN_RAIL_LSB        3
`define TSCAN_REFCUR_MSB      7
`define TSCAN_REFCUR_LSB      5
`define TSCAN_EXTCUR_MSB      2
`define TSCAN_EXTCUR_LSB      0
`define TSCAN_CNT_MAX         16'hffff

`endif

// ===== src/tscan_ctrl.v
/*
 touch scan control: start logic, electrode oscillator prescaler, scan
 counting, 16-bit result counter, end-of-scan flag, interrupt and wakeup.
 assumes the electrode oscillator arrives as a raw pin level and that
 timer triggers are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tscan_consts.vh"
// What this block does
// - sixteen electrodes, each enabled by its own bit across two enable bytes.
// - a two-bit rail field at bits 4-3 of the second control word picks one of four rail pairs.
// - current code 7 means 64 uA and code 4 means 8 uA for reference and electrode.
// - the prescaler divides by at most 128 and a measurement has at most 32 scans.
// - prescaler field n divides by two to the n, and scan field 0x0f gives 16 scans.
// - with trigger mode clear, a software start scans the channel picked by channel select.
// - with trigger mode set, a chosen timer event (rtc, timer 0, timer 2) starts a scan.
// - a 16-bit counter totals the charge and discharge time, readable after completion.
// - the total scales with prescale times scan count times reference over electrode current.
// - completion sets the end-of-scan flag, cleared by software writing one.
// - with interrupt enable set, completion raises the interrupt request.
// - with stop enable set, the block keeps working in stop mode.
// - in stop3 mode completion wakes the cpu.
module tscan_ctrl (
	// clock and reset
	input  wire        ref_clk_in,
	input  wire        rst_n_in,
	// control bits
	input  wire        module_enable_in,
	input  wire        trigger_mode_select_in,
	input  wire        software_scan_start_in,
	input  wire [1:0]  trigger_source_in,
	input  wire        scan_irq_enable_in,
	input  wire        stop_mode_enable_in,
	input  wire        stop_mode_in,
	input  wire        stop3_mode_in,
	input  wire        end_of_scan_clear_in,
	input  wire [3:0]  channel_select_in,
	input  wire [7:0]  electrode_enable_low_in,
	input  wire [7:0]  electrode_enable_high_in,
	input  wire [2:0]  electrode_osc_divider_in,
	input  wire [4:0]  scan_count_in,
	input  wire [7:0]  control_status_2_in,
	// hardware triggers
	input  wire        rtc_trigger_in,
	input  wire        modulo_timer_0_trigger_in,
	input  wire        timer_2_trigger_in,
	// oscillators
	input  wire        electrode_osc_in,
	input  wire        reference_osc_in,
	// results
	output reg  [15:0] scan_counter_value_out,
	output reg         end_of_scan_flag_out,
	output reg         scan_busy_out,
	output reg         scan_irq_out,
	output reg         wakeup_out,
	output reg  [15:0] electrode_select_out,
	output reg  [1:0]  rail_voltage_select_out,
	output reg  [2:0]  reference_current_select_out,
	output reg  [2:0]  electrode_current_select_out
);
	// scan sequencer states
	localparam ST_IDLE = 2'h0;
	localparam ST_SCAN = 2'h1;
	localparam ST_DONE = 2'h2;

	wire        ext_lvl;
	wire        ref_lvl;
	reg         ext_prev;
	reg         ref_prev;
	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [6:0]  div_cnt;
	reg  [5:0]  scans_left;
	reg         sw_prev;
	reg         hw_trig;
	reg         armed;
	wire [15:0] pin_en;
	wire        run_ok;
	wire        start_req;
	wire        take_start;
	wire        ext_rise;
	wire        ref_rise;
	wire        div_wrap;
	wire [6:0]  div_limit;

	// both pins see the same sync lag, so their edges keep their spacing
	tscan_sync u_ext (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.async_in   (electrode_osc_in),
		.level_out  (ext_lvl)
	);
	tscan_sync u_ref (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.async_in   (reference_osc_in),
		.level_out  (ref_lvl)
	);

	assign pin_en = {electrode_enable_high_in, electrode_enable_low_in};
	// stop mode halts scanning unless stop enable keeps it alive
	assign run_ok    = module_enable_in & (~stop_mode_in | stop_mode_enable_in);
	assign ext_rise  = ext_lvl & ~ext_prev;
	assign ref_rise  = ref_lvl & ~ref_prev;
	// divide ratio 2^n, n capped at 7 so the ratio tops at 128
	assign div_limit = (7'h01 << electrode_osc_divider_in) - 7'h01;
	// wrap only counts once the measuring window is open
	assign div_wrap  = ext_rise & armed & (div_cnt == div_limit);

	// trigger source mux, one event per pulse
	always @* begin
		case (trigger_source_in)
		`TSCAN_TRIG_RTC:    hw_trig = rtc_trigger_in;
		`TSCAN_TRIG_MODULO_TIMER_0:  hw_trig = modulo_timer_0_trigger_in;
		`TSCAN_TRIG_TIMER2: hw_trig = timer_2_trigger_in;
		default:            hw_trig = 1'b0;
		endcase
	end

	// software start is edge taken so a held bit starts one scan only
	assign start_req = run_ok & (trigger_mode_select_in ? hw_trig
		: (software_scan_start_in & ~sw_prev));
	// a start is taken in idle and in the done cycle too, so a request
	// made just after busy drops is not lost
	assign take_start = start_req & (state != ST_SCAN);

	// scan sequencing
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (take_start)
				next_state = ST_SCAN;
		end
		ST_SCAN: begin
			// losing enable or stop permission aborts without a flag
			if (!run_ok)
				next_state = ST_IDLE;
			else if (div_wrap && scans_left == 6'h01)
				next_state = ST_DONE;
		end
		ST_DONE: begin
			if (take_start)
				next_state = ST_SCAN;
			else
				next_state = ST_IDLE;
		end
		default: next_state = ST_IDLE;
		endcase
	end

	// counters, flag and registered outputs
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ST_IDLE;
			ext_prev <= 1'b0;
			ref_prev <= 1'b0;
			sw_prev <= 1'b0;
			armed <= 1'b0;
			div_cnt <= 7'h00;
			scans_left <= 6'h00;
			scan_counter_value_out <= `TSCAN_CNT_RESET;
			end_of_scan_flag_out <= 1'b0;
			scan_busy_out <= 1'b0;
			scan_irq_out <= 1'b0;
			wakeup_out <= 1'b0;
			electrode_select_out <= 16'h0000;
			rail_voltage_select_out <= 2'h0;
			reference_current_select_out <= 3'h0;
			electrode_current_select_out <= 3'h0;
		end else begin
			state <= next_state;
			ext_prev <= ext_lvl;
			ref_prev <= ref_lvl;
			sw_prev <= software_scan_start_in;
			// analog codes pass through; 7 = 64 uA, 4 = 8 uA
			rail_voltage_select_out <=
				control_status_2_in[`TSCAN_RAIL_MSB:`TSCAN_RAIL_LSB];
			reference_current_select_out <=
				control_status_2_in[`TSCAN_REFCUR_MSB:`TSCAN_REFCUR_LSB];
			electrode_current_select_out <=
				control_status_2_in[`TSCAN_EXTCUR_MSB:`TSCAN_EXTCUR_LSB];
			scan_busy_out <= (next_state == ST_SCAN);
			if (take_start) begin
				armed <= 1'b0;
				div_cnt <= 7'h00;
				scans_left <= {1'b0, scan_count_in} + 6'h01;
				scan_counter_value_out <= `TSCAN_CNT_RESET;
				// only an enabled electrode is routed to the oscillator
				electrode_select_out <= pin_en &
					(16'h0001 << channel_select_in);
			end else if (state == ST_SCAN) begin
				// window opens on the first electrode edge, so a scan never
				// counts a partial oscillator period before it
				if (ext_rise && !armed)
					armed <= 1'b1;
				// reference cycles over the prescaled electrode window;
				// saturates rather than wrapping to a small, false total
				if (armed && ref_rise && scan_counter_value_out != `TSCAN_CNT_MAX)
					scan_counter_value_out <= scan_counter_value_out + 16'h0001;
				if (ext_rise && armed)
					div_cnt <= div_wrap ? 7'h00 : div_cnt + 7'h01;
				if (div_wrap)
					scans_left <= scans_left - 6'h01;
			end else if (state == ST_DONE) begin
				electrode_select_out <= 16'h0000;
			end
			// set wins over a clear in the same cycle
			if (state == ST_DONE)
				end_of_scan_flag_out <= 1'b1;
			else if (end_of_scan_clear_in)
				end_of_scan_flag_out <= 1'b0;
			// request follows the flag, so it clears one cycle after it
			scan_irq_out <= scan_irq_enable_in &
				(end_of_scan_flag_out | state == ST_DONE);
			wakeup_out <= stop3_mode_in & (state == ST_DONE);
		end
	end
endmodule // tscan_ctrl
`default_nettype wire

// ===== src/tscan_sync.v
/*
 three-stage synchroniser with agreement of the last two stages.
 assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tscan_sync (
	// clock and reset
	input  wire ref_clk_in,
	input  wire rst_n_in,
	// raw and clean level
	input  wire async_in,
	output reg  level_out
);
	reg s1;
	reg s2;
	reg s3;

	// first stage only feeds the second
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				level_out <= s3; // change counts once stages agree
		end
	end
endmodule // tscan_sync
`default_nettype wire

// ===== tb/touch_scan_control_bench.sv
/* self-checking bench for the touch scan control block.
 assumes the oscillator model on the pins and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module touch_scan_control_bench;
	reg ref_clk_in = 1'b0, rst_n_in = 1'b0, module_enable_in = 1'b1, trigger_mode_select_in = 1'b0;
	reg software_scan_start_in = 1'b0, scan_irq_enable_in = 1'b1, stop_mode_enable_in = 1'b1;
	reg stop_mode_in = 1'b0, stop3_mode_in = 1'b0, end_of_scan_clear_in = 1'b0;
	reg rtc_trigger_in = 1'b0, modulo_timer_0_trigger_in = 1'b0, timer_2_trigger_in = 1'b0;
	reg [1:0] trigger_source_in = 2'h3;
	reg [3:0] channel_select_in = 4'h1;
	reg [7:0] electrode_enable_low_in = 8'h0f, electrode_enable_high_in = 8'h00;
	reg [7:0] control_status_2_in = 8'hec;
	reg [2:0] electrode_osc_divider_in = 3'h2;
	reg [4:0] scan_count_in = 5'h0f;
	reg [31:0] rnd = 32'he775b65d;
	wire electrode_osc_in, reference_osc_in, end_of_scan_flag_out, scan_busy_out;
	wire scan_irq_out, wakeup_out;
	wire [15:0] scan_counter_value_out, electrode_select_out;
	wire [1:0] rail_voltage_select_out;
	wire [2:0] reference_current_select_out, electrode_current_select_out;
	wire [7:0] codes_seen = {reference_current_select_out, rail_voltage_select_out,
		electrode_current_select_out};
	reg [15:0] sel_want;
	integer err_total = 0, comparisons = 0, cycles = 0, i, n;
	integer exp_q[$];
	tscan_ctrl dut_u (.*);
	tsc_osc_model osc_u (.electrode_osc_out(electrode_osc_in), .reference_osc_out(reference_osc_in));
	initial begin
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	task step; begin @(posedge ref_clk_in); #1; end endtask
	task close_out;
		begin
			$display("mismatches %0d comparisons %0d", err_total, comparisons);
			if (err_total == 0 && comparisons > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	task check_bit(input got, input want);
		begin
			comparisons = comparisons + 1;
			if (got !== want) begin
				err_total = err_total + 1;
				$display("CHECK FAILED %0t status %b not %b", $time, got, want);
			end
		end
	endtask
	// the count may slip up to two reference edges either side through the synchroniser
	task check_cnt(input [15:0] got, input integer want);
		begin
			comparisons = comparisons + 1;
			if ((got + 2 >= want && got <= want + 2) !== 1'b1) begin
				err_total = err_total + 1;
				$display("CHECK FAILED %0t count %0d not %0d", $time, got, want);
			end
		end
	endtask
	task check_word(input [15:0] got, input [15:0] want);
		begin
			comparisons = comparisons + 1;
			if (got !== want) begin
				err_total = err_total + 1;
				$display("CHECK FAILED %0t word %h not %h", $time, got, want);
			end
		end
	endtask
	// how: 0..2 timer source, 3 software start; 4 reference edges per electrode edge
	task measure(input integer how, input [2:0] div, input [4:0] nsc);
		begin
			{electrode_osc_divider_in, scan_count_in} = {div, nsc};
			trigger_mode_select_in = (how < 3);
			trigger_source_in = how[1:0];
			exp_q.push_back((1 << div) * (nsc + 1) * 4);
			step;
			software_scan_start_in = (how == 3);
			{timer_2_trigger_in, modulo_timer_0_trigger_in, rtc_trigger_in} = 3'h1 << how;
			step;
			{software_scan_start_in, timer_2_trigger_in, modulo_timer_0_trigger_in, rtc_trigger_in} = 4'h0;
			sel_want = {electrode_enable_high_in, electrode_enable_low_in} & (16'h0001 << channel_select_in);
			check_word(electrode_select_out, sel_want);
			check_word({8'h00, codes_seen}, {8'h00, control_status_2_in});
			for (i = 0; i < 3000 && end_of_scan_flag_out !== 1'b1; i = i + 1) step;
			check_bit(end_of_scan_flag_out, 1'b1);
			repeat (3) step;
			check_bit(end_of_scan_flag_out, 1'b1);
			end_of_scan_clear_in = 1'b1;
			step;
			end_of_scan_clear_in = 1'b0;
			step;
			check_bit(end_of_scan_flag_out, 1'b0);
		end
	endtask
	// watcher: every new flag consumes the oldest expected count
	always @(posedge end_of_scan_flag_out) begin
		#2;
		if (exp_q.size() == 0) check_bit(1'b1, 1'b0);
		else check_cnt(scan_counter_value_out, exp_q.pop_front());
		check_bit(scan_irq_out, scan_irq_enable_in);
		check_bit(wakeup_out, stop3_mode_in);
	end
	// hang guard
	always @(posedge ref_clk_in) begin
		cycles = cycles + 1;
		if (cycles == 30000) begin
			err_total = err_total + 1;
			close_out;
		end
	end
	initial begin
		repeat (16) step;
		rst_n_in = 1'b1;
		step;
		measure(3, 3'h2, 5'h0f);
		for (n = 0; n < 12; n = n + 1) begin
			rnd = rnd ^ (rnd << 13);
			rnd = rnd ^ (rnd >> 17);
			rnd = rnd ^ (rnd << 5);
			{channel_select_in, electrode_enable_high_in, electrode_enable_low_in} = rnd[19:0];
			{control_status_2_in, stop_mode_in, stop3_mode_in} = rnd[29:20];
			scan_irq_enable_in = rnd[12];
			measure(n % 4, {1'b0, rnd[31:30]}, {3'h0, rnd[1:0]});
		end
		// longest scan, so the abort below lands inside the window
		{electrode_osc_divider_in, scan_count_in} = {3'h7, 5'h1f};
		module_enable_in = 1'b0;
		software_scan_start_in = 1'b1;
		repeat (2) step;
		check_bit(scan_busy_out, 1'b0);
		{module_enable_in, software_scan_start_in} = 2'h2;
		step;
		software_scan_start_in = 1'b1;
		repeat (20) step;
		check_bit(scan_busy_out, 1'b1);
		module_enable_in = 1'b0;
		repeat (2) step;
		check_bit(scan_busy_out, 1'b0);
		{module_enable_in, software_scan_start_in} = 2'h2;
		// stop mode without stop enable refuses a start
		{stop_mode_in, stop_mode_enable_in} = 2'h2;
		step;
		software_scan_start_in = 1'b1;
		repeat (2) step;
		check_bit(scan_busy_out, 1'b0);
		{software_scan_start_in, stop_mode_in, stop_mode_enable_in} = 3'h1;
		repeat (600) step;
		close_out;
	end
endmodule // touch_scan_control_bench
`default_nettype wire

// ===== tb/tsc_ctrl_asserts.sv
/* port-level checks of the touch scan control block.
 assumes binding into tscan_ctrl, one clock, active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module tsc_ctrl_asserts (
	// watched pins
	input wire logic       ref_clk_in, rst_n_in, module_enable_in, trigger_mode_select_in,
	input wire logic       software_scan_start_in, end_of_scan_clear_in, modulo_timer_0_trigger_in,
	input wire logic       scan_busy_out, end_of_scan_flag_out, wakeup_out,
	input wire logic       stop_mode_in, stop_mode_enable_in, scan_irq_enable_in, scan_irq_out,
	input wire logic [1:0] trigger_source_in, rail_voltage_select_out,
	input wire logic [7:0] control_status_2_in,
	input wire logic [2:0] reference_current_select_out, electrode_current_select_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// end of a scan is the busy level dropping
	sequence s_done;
		$fell(scan_busy_out);
	endsequence
	AST_CODES: assert property ($past(rst_n_in) |-> { reference_current_select_out,
		rail_voltage_select_out, electrode_current_select_out} == $past(control_status_2_in))
		else $error("code outputs differ from control word");
	AST_SW_START: assert property (module_enable_in && !trigger_mode_select_in && !scan_busy_out
		&& !(stop_mode_in && !stop_mode_enable_in)
		&& $rose(software_scan_start_in) |=> scan_busy_out) else $error("software start lost");
	AST_HW_START: assert property (module_enable_in && trigger_mode_select_in && !scan_busy_out
		&& !(stop_mode_in && !stop_mode_enable_in)
		&& trigger_source_in == 2'h1 && modulo_timer_0_trigger_in |=> scan_busy_out)
		else $error("timer trigger lost");
	AST_DISABLED: assert property (!module_enable_in |=> !scan_busy_out) else $error("busy while off");
	AST_FLAG_HOLD: assert property (end_of_scan_flag_out && !end_of_scan_clear_in
		|=> end_of_scan_flag_out) else $error("flag dropped");
	// the edge where busy has just fallen is the set edge, and set wins
	AST_FLAG_CLR: assert property (end_of_scan_clear_in && !scan_busy_out
		&& !$fell(scan_busy_out) |=> !end_of_scan_flag_out) else $error("flag not cleared");
	AST_DONE_FLAG: assert property (s_done and (module_enable_in && $past(module_enable_in)
		&& !$past(stop_mode_in && !stop_mode_enable_in)) |=> end_of_scan_flag_out)
		else $error("scan ended without flag");
	AST_WAKE: assert property (wakeup_out |-> end_of_scan_flag_out && !$past(scan_busy_out)
		&& $past(scan_busy_out, 2) ##1 !wakeup_out) else $error("bad wakeup");
	AST_IRQ: assert property ($past(scan_irq_enable_in) && end_of_scan_flag_out |-> scan_irq_out)
		else $error("interrupt missing");
	AST_IRQ_OFF: assert property (!$past(scan_irq_enable_in) |-> !scan_irq_out)
		else $error("interrupt while disabled");
endmodule // tsc_ctrl_asserts
bind tscan_ctrl tsc_ctrl_asserts chk_u (.*);
`default_nettype wire

// ===== tb/tsc_osc_model.sv
/* electrode and reference oscillator pins driven into the scan block.
 assumes a 1ns time unit; both run free, as real oscillators do. */
`timescale 1ns/1ps
`default_nettype none
module tsc_osc_model #(
	parameter integer EL_HALF  = 80,
	parameter integer REF_HALF = 20
) (
	// oscillator pins
	output var logic electrode_osc_out,
	output var logic reference_osc_out
);
	// odd offsets keep edges clear of the 100 MHz clock edges
	initial begin
		electrode_osc_out = 1'b0;
		#3;
		forever #(EL_HALF) electrode_osc_out = ~electrode_osc_out;
	end
	initial begin
		reference_osc_out = 1'b0;
		#7;
		forever #(REF_HALF) reference_osc_out = ~reference_osc_out;
	end
endmodule // tsc_osc_model
`default_nettype wire
